// [design/pif_pkg.sv]
// Package: register map, field positions, reset values and timing for the
// peripheral interrupt flag block.
// Assumes one 10 MHz clock and a byte-wide register port with 16-bit address.
package pif_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] OFS_IRQ_ENABLE = 16'hFF23;
  localparam logic [15:0] OFS_IRQ_PENDING = 16'hFF25;
  localparam logic [15:0] OFS_IRQ_PRIORITY = 16'hFF20;
  localparam logic [15:0] OFS_SER_MODE = 16'hFF48;
  localparam logic [15:0] OFS_SER_TRIGGER = 16'hFF49;
  localparam logic [15:0] OFS_SER_DATA = 16'hFF4A;
  localparam logic [15:0] OFS_CPU_MASK = 16'hFF30;

  // ---------------------------------------------------------------
  // Source bit positions in enable and pending
  // ---------------------------------------------------------------
  localparam int BIT_TIMER1 = 7;
  localparam int BIT_TIMER0 = 6;
  localparam int BIT_KEY_GRP1 = 5;
  localparam int BIT_KEY_UPPER = 4;
  localparam int BIT_KEY_LOWER = 3;
  localparam int BIT_SER_ERROR = 2;
  localparam int BIT_SER_RX = 1;
  localparam int BIT_SER_TX = 0;

  // ---------------------------------------------------------------
  // Serial mode and trigger fields
  // ---------------------------------------------------------------
  localparam int MODE_SERIAL_SEL = 0;
  localparam int MODE_MASTER = 4;
  localparam int TRG_TX_EN = 0;
  localparam int TRG_TX_GO = 1;
  localparam int TRG_RX_EN = 2;
  localparam int TRG_RX_GO = 3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_PENDING = 8'h00;
  localparam logic [7:0] RST_PRIORITY = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [1:0] RST_CPU_MASK = 2'h0;

  // ---------------------------------------------------------------
  // Timing: shift clock is the low frequency oscillator divided by one
  // ---------------------------------------------------------------
  localparam int SHIFT_DIV = 1;
  localparam int BYTE_BITS = 8;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_LOW = 2'b01,
    SH_HIGH = 2'b11,
    SH_DONE = 2'b10
  } shift_state_e;

endpackage

// [design/peripheral_interrupt_flag_control.sv]
// Interrupt enable and pending flags with a clock-synchronous serial master.
// Assumes a single-cycle register port; slave drives ready low when ready.
//
// Operation
// R1: Eight-bit enable register: timers, three key groups, serial error, rx, tx.
// R2: Enable bits read/write, zero at reset; one permits the source.
// R3: Pending register same order; flag set by its source, zero at reset.
// R4: Writing one clears a pending flag; zero leaves it alone.
// R5: Software writes ones only to flags it means to clear.
// R6: Serial mode sets direction of data in, data out, clock and ready pins.
// R7: Master shift clock is oscillator tick divided by one, driven out.
// R8: Slave signals readiness; master checks it before each byte.
// R9: Trigger register read shows the opposite direction's status.
// R10: Software reads triggers first and writes ones only where needed.
// R11: CPU mask blocks lower levels until reset or flag cleared.
// R12: Request per source only while flag and enable both one, at its level.
`timescale 1ns/100ps
module peripheral_interrupt_flag_control #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [15:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // Event sources
  input wire logic i_timer1_evt,
  input wire logic i_timer0_evt,
  input wire logic i_key_grp1_evt,
  input wire logic i_key_upper_evt,
  input wire logic i_key_lower_evt,
  input wire logic i_low_freq_oscillator,
  // Serial pins
  input wire logic i_serial_data_in,
  input wire logic i_slave_ready_input,
  output logic o_serial_data_out,
  output logic o_serial_clk,
  output logic o_serial_clk_oe,
  output logic o_serial_data_out_oe,
  output logic [3:0] o_port_dir,
  // Interrupt
  output logic o_irq,
  output logic [1:0] o_irq_level
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (DATA_W != 8) begin : g_bad_width
    $error("DATA_W must be 8");
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] irq_enable;
  logic [7:0] irq_pending;
  logic [7:0] irq_priority;
  logic [7:0] ser_mode;
  logic [1:0] cpu_mask;
  logic tx_en, rx_en, tx_busy, rx_busy;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt;
  logic [7:0] sev;
  logic ser_err_evt, ser_rx_evt, ser_tx_evt;
  logic shift_tick;
  pif_pkg::shift_state_e sh_state;
  logic [7:0] req;
  logic [1:0] lvl_timer, lvl_key, lvl_ser, next_level;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  wire logic wr_en = i_wr && hit(i_addr, pif_pkg::OFS_IRQ_ENABLE);
  wire logic wr_pend = i_wr && hit(i_addr, pif_pkg::OFS_IRQ_PENDING);
  wire logic wr_trg = i_wr && hit(i_addr, pif_pkg::OFS_SER_TRIGGER);
  wire logic serial_on = ser_mode[pif_pkg::MODE_SERIAL_SEL];
  wire logic master = ser_mode[pif_pkg::MODE_MASTER];

  // ---------------------------------------------------------------
  // Enable, priority and serial mode registers
  // ---------------------------------------------------------------
  // R1 R2 enable storage
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_enable <= pif_pkg::RST_ENABLE;
    end else if (wr_en) begin
      irq_enable <= i_wdata;
    end
  end

  // Priority levels per source group
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_priority <= pif_pkg::RST_PRIORITY;
    end else if (i_wr && hit(i_addr, pif_pkg::OFS_IRQ_PRIORITY)) begin
      irq_priority <= i_wdata;
    end
  end

  // Serial mode selection
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ser_mode <= pif_pkg::RST_MODE;
    end else if (i_wr && hit(i_addr, pif_pkg::OFS_SER_MODE)) begin
      ser_mode <= i_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Pending flags
  // ---------------------------------------------------------------
  always_comb begin
    sev = 8'h00;
    sev[pif_pkg::BIT_TIMER1] = i_timer1_evt;
    sev[pif_pkg::BIT_TIMER0] = i_timer0_evt;
    sev[pif_pkg::BIT_KEY_GRP1] = i_key_grp1_evt;
    sev[pif_pkg::BIT_KEY_UPPER] = i_key_upper_evt;
    sev[pif_pkg::BIT_KEY_LOWER] = i_key_lower_evt;
    sev[pif_pkg::BIT_SER_ERROR] = ser_err_evt;
    sev[pif_pkg::BIT_SER_RX] = ser_rx_evt;
    sev[pif_pkg::BIT_SER_TX] = ser_tx_evt;
  end

  // R3 R4 set wins over write-one clear
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_pending <= pif_pkg::RST_PENDING;
    end else begin
      irq_pending <= (irq_pending & ~(wr_pend ? i_wdata : 8'h00)) | sev;
    end
  end

  // ---------------------------------------------------------------
  // Serial master: triggers, shift clock and shifter
  // ---------------------------------------------------------------
  // R7 shift clock tick from oscillator, divide by one
  assign shift_tick = i_low_freq_oscillator;

  // R8 start requires slave ready low, no wait
  wire logic ready_ok = !i_slave_ready_input;
  wire logic go_tx = wr_trg && i_wdata[pif_pkg::TRG_TX_GO] && tx_en && !tx_busy;
  wire logic go_rx = wr_trg && i_wdata[pif_pkg::TRG_RX_GO] && rx_en && !rx_busy;
  // R8 start refused with serial off or slave not ready raises the error flag
  assign ser_err_evt = (go_tx || go_rx) && (!serial_on || !ready_ok);

  // Trigger enable bits
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_en <= 1'b0;
      rx_en <= 1'b0;
    end else if (wr_trg) begin
      tx_en <= i_wdata[pif_pkg::TRG_TX_EN];
      rx_en <= i_wdata[pif_pkg::TRG_RX_EN];
    end
  end

  // R7 shifter: data out on the fall, data in taken on the rise
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_state <= pif_pkg::SH_IDLE;
      tx_busy <= 1'b0;
      rx_busy <= 1'b0;
      shift_reg <= 8'h00;
      bit_cnt <= 4'h0;
      o_serial_clk <= 1'b1;
      o_serial_data_out <= 1'b1;
      ser_rx_evt <= 1'b0;
      ser_tx_evt <= 1'b0;
    end else begin
      ser_rx_evt <= 1'b0;
      ser_tx_evt <= 1'b0;
      case (sh_state)
        pif_pkg::SH_IDLE: begin
          if ((go_tx || go_rx) && serial_on && master && ready_ok) begin
            tx_busy <= go_tx;
            rx_busy <= go_rx;
            if (go_tx && i_wr && hit(i_addr, pif_pkg::OFS_SER_DATA)) begin
              shift_reg <= i_wdata;
            end
            bit_cnt <= 4'h0;
            sh_state <= pif_pkg::SH_LOW;
          end else if (i_wr && hit(i_addr, pif_pkg::OFS_SER_DATA)) begin
            shift_reg <= i_wdata;
          end
        end
        pif_pkg::SH_LOW: begin
          if (shift_tick) begin
            o_serial_clk <= 1'b0;
            o_serial_data_out <= shift_reg[0];
            sh_state <= pif_pkg::SH_HIGH;
          end
        end
        pif_pkg::SH_HIGH: begin
          if (shift_tick) begin
            o_serial_clk <= 1'b1;
            shift_reg <= {i_serial_data_in, shift_reg[7:1]};
            bit_cnt <= bit_cnt + 4'h1;
            sh_state <= (bit_cnt == 4'(pif_pkg::BYTE_BITS - 1)) ?
              pif_pkg::SH_DONE : pif_pkg::SH_LOW;
          end
        end
        pif_pkg::SH_DONE: begin
          ser_tx_evt <= tx_busy;
          ser_rx_evt <= rx_busy;
          tx_busy <= 1'b0;
          rx_busy <= 1'b0;
          o_serial_data_out <= 1'b1;
          sh_state <= pif_pkg::SH_IDLE;
        end
        default: sh_state <= pif_pkg::SH_IDLE;
      endcase
    end
  end

  // R6 pin direction follows serial mode
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_port_dir <= 4'h0;
      o_serial_clk_oe <= 1'b0;
      o_serial_data_out_oe <= 1'b0;
    end else begin
      o_port_dir <= serial_on ? {1'b0, master, 1'b1, 1'b0} : 4'h0;
      o_serial_clk_oe <= serial_on && master;
      o_serial_data_out_oe <= serial_on;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt request and CPU mask
  // ---------------------------------------------------------------
  // R12 request needs flag and enable
  assign req = irq_pending & irq_enable;
  assign lvl_timer = irq_priority[1:0];
  assign lvl_key = irq_priority[3:2];
  assign lvl_ser = irq_priority[5:4];

  always_comb begin
    next_level = 2'h0;
    if (|req[pif_pkg::BIT_SER_ERROR:pif_pkg::BIT_SER_TX] && lvl_ser > next_level) begin
      next_level = lvl_ser;
    end
    if (|req[pif_pkg::BIT_KEY_GRP1:pif_pkg::BIT_KEY_LOWER] && lvl_key > next_level) begin
      next_level = lvl_key;
    end
    if (|req[pif_pkg::BIT_TIMER1:pif_pkg::BIT_TIMER0] && lvl_timer > next_level) begin
      next_level = lvl_timer;
    end
  end

  // R11 mask raised on accept, lowered by write or flag clear
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cpu_mask <= pif_pkg::RST_CPU_MASK;
    end else if (i_wr && hit(i_addr, pif_pkg::OFS_CPU_MASK)) begin
      cpu_mask <= i_wdata[1:0];
    end else if (wr_pend && |(i_wdata & irq_pending)) begin
      cpu_mask <= 2'h0;
    end else if (o_irq) begin
      cpu_mask <= o_irq_level;
    end
  end

  // R12 request pulse and its level
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
      o_irq_level <= 2'h0;
    end else begin
      o_irq <= (next_level > cpu_mask) && !o_irq;
      o_irq_level <= next_level;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        pif_pkg::OFS_IRQ_ENABLE: o_rdata <= irq_enable;
        pif_pkg::OFS_IRQ_PENDING: o_rdata <= irq_pending;
        pif_pkg::OFS_IRQ_PRIORITY: o_rdata <= irq_priority;
        pif_pkg::OFS_SER_MODE: o_rdata <= ser_mode;
        // R9 triggers read as opposite status
        pif_pkg::OFS_SER_TRIGGER: o_rdata <= {4'h0, tx_busy, rx_en, rx_busy, tx_en};
        pif_pkg::OFS_SER_DATA: o_rdata <= shift_reg;
        pif_pkg::OFS_CPU_MASK: o_rdata <= {6'h00, cpu_mask};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule // peripheral_interrupt_flag_control

// [dv/pif_sva.sv]
// Checker: port-level assertions for the interrupt flag block.
// Assumes the top module's ports only; bound at the foot of this file.
`timescale 1ns/100ps
module pif_sva #(parameter int DATA_W = 8) (
  // Clock, reset and register port
  input wire logic i_mclk, i_rst_n, i_wr, i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata, o_rdata,
  // Events and serial pins
  input wire logic i_timer1_evt, i_timer0_evt, i_key_grp1_evt,
  input wire logic i_key_upper_evt, i_key_lower_evt, i_low_freq_oscillator,
  input wire logic i_serial_data_in, i_slave_ready_input, o_serial_data_out,
  input wire logic o_serial_clk, o_serial_clk_oe, o_serial_data_out_oe,
  input wire logic [3:0] o_port_dir,
  // Interrupt
  input wire logic o_irq,
  input wire logic [1:0] o_irq_level
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] en_copy;
  logic [4:0] pend_copy;
  logic [4:0] pend_clr;
  assign pend_clr = (i_wr && i_addr == pif_pkg::OFS_IRQ_PENDING) ? i_wdata[7:3] : 5'h00;
  // Copy of the enable register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n)
      en_copy <= 8'h00;
    else if (i_wr && i_addr == pif_pkg::OFS_IRQ_ENABLE)
      en_copy <= i_wdata[7:0];
  end
  // Copy of the five event flags, set wins over clear
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n)
      pend_copy <= 5'h00;
    else
      pend_copy <= (pend_copy & ~pend_clr) | {i_timer1_evt, i_timer0_evt, i_key_grp1_evt,
        i_key_upper_evt, i_key_lower_evt};
  end
  AST_EN_RW: assert property (
    (i_rd && i_addr == pif_pkg::OFS_IRQ_ENABLE)
    |=> o_rdata == $past(en_copy)) else $error("enable readback wrong");
  AST_PEND_SET: assert property (
    (i_rd && i_addr == pif_pkg::OFS_IRQ_PENDING)
    |=> (o_rdata[7:3] & $past(pend_copy)) == $past(pend_copy))
    else $error("event flag not set");
  AST_W1C: assert property (
    (i_rd && i_addr == pif_pkg::OFS_IRQ_PENDING)
    |=> (o_rdata[7:3] & ~$past(pend_copy)) == 5'h00) else $error("flag not cleared");
  AST_RDATA_IDLE: assert property (
    !$past(i_rd) |-> o_rdata == '0) else $error("read data outside read slot");
  AST_CLK_DIR: assert property (
    o_serial_clk_oe == o_port_dir[2]) else $error("clock direction mismatch");
  AST_OUT_DIR: assert property (
    o_serial_data_out_oe == o_port_dir[1]) else $error("data out direction mismatch");
  AST_IN_DIR: assert property (
    o_port_dir[3] == 1'b0 && o_port_dir[0] == 1'b0) else $error("input pin driven");
  AST_CLK_TICK: assert property (
    $changed(o_serial_clk) |-> $past(i_low_freq_oscillator)) else $error("clock without tick");
  AST_IRQ_EN: assert property (
    o_irq |-> ($past(en_copy) | $past(en_copy, 2)) != 8'h00) else $error("request while disabled");
  AST_IRQ_MASK: assert property (
    o_irq |=> !o_irq) else $error("request repeated under mask");
endmodule // pif_sva
bind peripheral_interrupt_flag_control pif_sva #(.DATA_W(DATA_W)) u_sva (.*);

// [dv/pif_slave_model.sv]
// Partner: clock synchronous serial slave with a ready handshake.
// Assumes a master clock idle high, LSB first, data sampled on the rise.
`timescale 1ns/100ps
module pif_slave_model (
  // Master side pins
  input wire logic i_sclk,
  input wire logic i_sdo,
  // Test controls
  input wire logic i_ready,
  input wire logic [7:0] i_tx_byte,
  // Slave outputs
  output logic o_sdi,
  output logic o_ready_n,
  output logic [7:0] o_rx_byte
);
  int cnt = 0;
  logic [7:0] sh = 8'h00;
  initial o_sdi = 1'b0;
  initial o_rx_byte = 8'h00;
  assign o_ready_n = !i_ready;
  // Data changes after the falling clock
  always @(negedge i_sclk) o_sdi = i_tx_byte[cnt];
  always @(posedge i_sclk) begin
    if (!i_ready)
      cnt = 0;
    else begin
      sh = {i_sdo, sh[7:1]};
      cnt = cnt + 1;
      if (cnt == 8) begin
        cnt = 0;
        o_rx_byte = sh;
        // Line shows the inverse once the byte is done
        o_sdi = !o_sdi;
      end
    end
  end
endmodule // pif_slave_model

// [dv/peripheral_interrupt_flag_control_tb.sv]
// Testbench: register access, events, interrupt and serial transfers.
// Assumes the slave model and the bound checker are compiled first.
`timescale 1ns/100ps
module peripheral_interrupt_flag_control_tb;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, rdy = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00, rdv = 8'h00, tx_byte = 8'h00, rx_byte, rdata;
  logic [4:0] ev = 5'h00;
  logic sdi, rdy_n, sdo, sclk, irq, clk_oe, dout_oe;
  logic osc = 1'b0;
  logic [3:0] dir;
  logic [1:0] lvl;
  int failures = 0, total_checks = 0, irqs = 0, base = 0;
  always #50 i_mclk = ~i_mclk;
  always @(posedge i_mclk) osc <= !osc;
  always @(posedge i_mclk) begin
    if (irq === 1'b1)
      irqs <= irqs + 1;
  end
  peripheral_interrupt_flag_control uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
    .i_timer1_evt(ev[4]), .i_timer0_evt(ev[3]), .i_key_grp1_evt(ev[2]),
    .i_key_upper_evt(ev[1]), .i_key_lower_evt(ev[0]), .i_low_freq_oscillator(osc),
    .i_serial_data_in(sdi), .i_slave_ready_input(rdy_n), .o_serial_data_out(sdo),
    .o_serial_clk(sclk), .o_serial_clk_oe(clk_oe), .o_serial_data_out_oe(dout_oe),
    .o_port_dir(dir),
    .o_irq(irq), .o_irq_level(lvl));
  pif_slave_model slave (.i_sclk(sclk), .i_sdo(sdo), .i_ready(rdy), .i_tx_byte(tx_byte),
    .o_sdi(sdi), .o_ready_n(rdy_n), .o_rx_byte(rx_byte));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 rdv = rdata;
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] exp);
    rd(a);
    chk(rdv, exp);
  endtask
  task automatic pulse(input logic [4:0] v);
    @(posedge i_mclk);
    ev <= v;
    @(posedge i_mclk);
    ev <= 5'h00;
  endtask
  task automatic waitp(input int b);
    rdv = 8'h00;
    for (int n = 0; n < 60 && rdv[b] !== 1'b1; n++)
      rd(pif_pkg::OFS_IRQ_PENDING);
  endtask
  task automatic tdone(input string name);
    $display("test %s ended, checks %0d failures %0d", name, total_checks, failures);
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(2000 * 100);
    failures++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rc(pif_pkg::OFS_IRQ_ENABLE, 8'h00);
    rc(pif_pkg::OFS_IRQ_PENDING, 8'h00);
    rc(16'h1234, 8'h00);
    wr(pif_pkg::OFS_IRQ_ENABLE, 8'hA5);
    rc(pif_pkg::OFS_IRQ_ENABLE, 8'hA5);
    wr(pif_pkg::OFS_IRQ_ENABLE, 8'h00);
    tdone("registers");
    pulse(5'h1F);
    rc(pif_pkg::OFS_IRQ_PENDING, 8'hF8);
    wr(pif_pkg::OFS_IRQ_PENDING, 8'h80);
    rc(pif_pkg::OFS_IRQ_PENDING, 8'h78);
    wr(pif_pkg::OFS_IRQ_PENDING, 8'h00);
    rc(pif_pkg::OFS_IRQ_PENDING, 8'h78);
    wr(pif_pkg::OFS_IRQ_PENDING, 8'h78);
    rc(pif_pkg::OFS_IRQ_PENDING, 8'h00);
    tdone("flags");
    wr(pif_pkg::OFS_IRQ_PRIORITY, 8'h0A);
    wr(pif_pkg::OFS_CPU_MASK, 8'h00);
    wr(pif_pkg::OFS_IRQ_ENABLE, 8'h50);
    base = irqs;
    pulse(5'h10);
    repeat (4) @(posedge i_mclk);
    chk(8'(irqs - base), 8'h00);
    pulse(5'h08);
    repeat (4) @(posedge i_mclk);
    chk(8'(irqs - base), 8'h01);
    chk({6'h00, lvl}, 8'h02);
    pulse(5'h02);
    repeat (4) @(posedge i_mclk);
    chk(8'(irqs - base), 8'h01);
    wr(pif_pkg::OFS_IRQ_PENDING, 8'h50);
    pulse(5'h02);
    repeat (4) @(posedge i_mclk);
    chk(8'(irqs - base), 8'h02);
    wr(pif_pkg::OFS_IRQ_PENDING, 8'hF8);
    wr(pif_pkg::OFS_IRQ_ENABLE, 8'h00);
    tdone("interrupt");
    wr(pif_pkg::OFS_SER_MODE, 8'h11);
    repeat (2) @(posedge i_mclk);
    chk({2'b00, clk_oe, dout_oe, dir}, 8'h36);
    wr(pif_pkg::OFS_SER_TRIGGER, 8'h01);
    wr(pif_pkg::OFS_SER_TRIGGER, 8'h03);
    rc(pif_pkg::OFS_IRQ_PENDING, 8'h04);
    wr(pif_pkg::OFS_IRQ_PENDING, 8'h04);
    rdy <= 1'b1;
    wr(pif_pkg::OFS_SER_DATA, 8'h3C);
    rd(pif_pkg::OFS_SER_TRIGGER);
    wr(pif_pkg::OFS_SER_TRIGGER, rdv | 8'h02);
    waitp(0);
    chk(rx_byte, 8'h3C);
    chk(rdv, 8'h01);
    wr(pif_pkg::OFS_IRQ_PENDING, 8'h01);
    tx_byte <= 8'hA6;
    wr(pif_pkg::OFS_SER_TRIGGER, 8'h04);
    wr(pif_pkg::OFS_SER_TRIGGER, 8'h0C);
    repeat (3) @(posedge i_mclk);
    rc(pif_pkg::OFS_SER_TRIGGER, 8'h06);
    waitp(1);
    chk(rdv, 8'h02);
    rc(pif_pkg::OFS_SER_DATA, 8'hA6);
    wr(pif_pkg::OFS_SER_MODE, 8'h00);
    repeat (2) @(posedge i_mclk);
    chk({2'b00, clk_oe, dout_oe, dir}, 8'h00);
    tdone("serial");
    pulse(5'h1F);
    wr(pif_pkg::OFS_IRQ_ENABLE, 8'h5A);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rc(pif_pkg::OFS_IRQ_ENABLE, 8'h00);
    rc(pif_pkg::OFS_IRQ_PENDING, 8'h00);
    tdone("reset");
    give_verdict();
  end
endmodule // peripheral_interrupt_flag_control_tb
